/* File: verilog/wq_cap_pkg.sv */
// Constants for the work-queue capability register block
package wq_cap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] CAP_OFFSET = 12'h020;
  localparam logic [63:0] RD_DATA_RESET = 64'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the capability word
  localparam int PRS_BIT = 55;
  localparam int OPFILT_BIT = 54;
  localparam int OCC_IRQ_BIT = 53;
  localparam int OCC_BIT = 52;
  localparam int PRIO_BIT = 51;
  localparam int ATS_BIT = 50;
  localparam int DED_BIT = 49;
  localparam int SHR_BIT = 48;
  localparam int CFG_SIZE_LSB = 24;
  localparam int CFG_SIZE_W = 4;
  localparam int NUM_Q_LSB = 16;
  localparam int NUM_Q_W = 8;
  localparam int TOTAL_LSB = 0;
  localparam int TOTAL_W = 16;
  localparam int CFG_SIZE_BASE = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Widths of the gated per-queue configuration fields
  localparam int PRIO_W = 4;
  localparam int OPF_W = 8;
  localparam int OCC_W = 16;

endpackage : wq_cap_pkg

/* File: verilog/work_queue_capability_register.sv */
// Work-queue capability register and the feature gating it implies
module work_queue_capability_register #(
  parameter logic PRS_SUPPORT = 1'b1,
  parameter logic OPFILT_SUPPORT = 1'b1,
  parameter logic OCC_IRQ_SUPPORT = 1'b1,
  parameter logic OCC_SUPPORT = 1'b1,
  parameter logic PRIO_SUPPORT = 1'b1,
  parameter logic ATS_SUPPORT = 1'b1,
  parameter logic DED_SUPPORT = 1'b1,
  parameter logic SHR_SUPPORT = 1'b1,
  parameter logic [3:0] CFG_SIZE_N = 4'h0,
  parameter logic [7:0] NUM_QUEUES = 8'h08,
  parameter logic [15:0] TOTAL_STORAGE = 16'h0080
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Memory-mapped register access, first base address region
  input wire logic [11:0] ADDR,
  input wire logic RD_REQ,
  input wire logic WR_REQ,
  input wire logic [63:0] WR_DATA,
  output logic [63:0] RD_DATA,
  output logic RD_ACK,
  output logic WR_ACK,
  // Per-queue configuration fields as software wrote them
  input wire logic WQ_PRS_DISABLE,
  input wire logic PRS_ENABLE,
  input wire logic WQ_ATS_DISABLE,
  input wire logic ATS_ENABLE,
  input wire logic [7:0] WQ_OP_FILTER,
  input wire logic [15:0] WQ_OCC_LIMIT,
  input wire logic WQ_OCC_IRQ_EN,
  input wire logic [15:0] WQ_LIVE_FILL,
  input wire logic [3:0] WQ_PRIORITY,
  input wire logic WQ_CFG_VALID,
  input wire logic WQ_MODE_DEDICATED,
  // Effective per-queue controls for the queue logic
  output logic PRS_USE,
  output logic ATS_USE,
  output logic [7:0] OP_ALLOWED,
  output logic [15:0] OCC_LIMIT_EFF,
  output logic OCC_IRQ_EN_EFF,
  output logic [15:0] OCC_REPORT,
  output logic [3:0] PRIORITY_EFF,
  output logic MODE_ERROR
);

  logic [63:0] cap_word;
  logic [63:0] rd_data_q;
  logic rd_ack_q;
  logic wr_ack_q;
  logic prs_use_q;
  logic ats_use_q;
  logic [7:0] op_allowed_q;
  logic [15:0] occ_limit_q;
  logic occ_irq_en_q;
  logic [15:0] occ_report_q;
  logic [3:0] priority_q;
  logic mode_error_q;
  logic cap_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Constant capability word; every bit not listed stays zero
  always_comb
  begin
    cap_word = '0;
    cap_word[wq_cap_pkg::PRS_BIT] = PRS_SUPPORT;
    cap_word[wq_cap_pkg::OPFILT_BIT] = OPFILT_SUPPORT;
    cap_word[wq_cap_pkg::OCC_IRQ_BIT] = OCC_IRQ_SUPPORT;
    cap_word[wq_cap_pkg::OCC_BIT] = OCC_SUPPORT;
    cap_word[wq_cap_pkg::PRIO_BIT] = PRIO_SUPPORT;
    cap_word[wq_cap_pkg::ATS_BIT] = ATS_SUPPORT;
    cap_word[wq_cap_pkg::DED_BIT] = DED_SUPPORT;
    cap_word[wq_cap_pkg::SHR_BIT] = SHR_SUPPORT;
    cap_word[wq_cap_pkg::CFG_SIZE_LSB +: wq_cap_pkg::CFG_SIZE_W] =
      CFG_SIZE_N;
    cap_word[wq_cap_pkg::NUM_Q_LSB +: wq_cap_pkg::NUM_Q_W] =
      NUM_QUEUES;
    cap_word[wq_cap_pkg::TOTAL_LSB +: wq_cap_pkg::TOTAL_W] =
      TOTAL_STORAGE;
  end

  // Address decode of the capability word
  assign cap_hit = (ADDR == wq_cap_pkg::CAP_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Read path: answer one cycle after the request, zero when unmapped
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      rd_data_q <= wq_cap_pkg::RD_DATA_RESET;
      rd_ack_q <= 1'b0;
    end
    else
    begin
      rd_ack_q <= RD_REQ;
      if (RD_REQ)
      begin
        rd_data_q <= cap_hit ? cap_word : '0;
      end
    end
  end

  // Writes are dropped, and acknowledged only when no read is requested in the same cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      wr_ack_q <= 1'b0;
    end
    else
    begin
      wr_ack_q <= WR_REQ & ~RD_REQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page-request and translation use per queue
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      prs_use_q <= 1'b0;
      ats_use_q <= 1'b0;
    end
    else
    begin
      prs_use_q <= PRS_ENABLE & ~(PRS_SUPPORT & WQ_PRS_DISABLE);
      ats_use_q <= ATS_ENABLE & ~(ATS_SUPPORT & WQ_ATS_DISABLE);
    end
  end

  // Operation filter: without support every advertised operation passes
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      op_allowed_q <= '0;
    end
    else
    begin
      op_allowed_q <= OPFILT_SUPPORT ? WQ_OP_FILTER : '1;
    end
  end

  // Occupancy limit, interrupt enable and reported fill level
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      occ_limit_q <= '0;
      occ_irq_en_q <= 1'b0;
      occ_report_q <= '0;
    end
    else
    begin
      occ_limit_q <= OCC_IRQ_SUPPORT ? WQ_OCC_LIMIT : '0;
      occ_irq_en_q <= OCC_IRQ_SUPPORT & WQ_OCC_IRQ_EN;
      occ_report_q <= OCC_SUPPORT ? WQ_LIVE_FILL : '0;
    end
  end

  // Priority is ignored when not supported
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      priority_q <= '0;
    end
    else
    begin
      priority_q <= PRIO_SUPPORT ? WQ_PRIORITY : '0;
    end
  end

  // Flags a queue configured in a mode the device lacks
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      mode_error_q <= 1'b0;
    end
    else
    begin
      mode_error_q <= WQ_CFG_VALID &
        (WQ_MODE_DEDICATED ? ~DED_SUPPORT : ~SHR_SUPPORT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  assign RD_DATA = rd_data_q;
  assign RD_ACK = rd_ack_q;
  assign WR_ACK = wr_ack_q;
  assign PRS_USE = prs_use_q;
  assign ATS_USE = ats_use_q;
  assign OP_ALLOWED = op_allowed_q;
  assign OCC_LIMIT_EFF = occ_limit_q;
  assign OCC_IRQ_EN_EFF = occ_irq_en_q;
  assign OCC_REPORT = occ_report_q;
  assign PRIORITY_EFF = priority_q;
  assign MODE_ERROR = mode_error_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_cap_read: assert property (
    RD_REQ && cap_hit |=> RD_ACK && RD_DATA == cap_word)
    else $error("capability read returned wrong word");

  chk_unmapped_zero: assert property (
    RD_REQ && !cap_hit |=> RD_ACK && RD_DATA == '0)
    else $error("unmapped read not zero");

  chk_prs_gate: assert property (
    PRS_SUPPORT && WQ_PRS_DISABLE |=> !PRS_USE)
    else $error("page-request disable not honoured");

  chk_filter_open: assert property (
    !OPFILT_SUPPORT |=> OP_ALLOWED == 8'hff)
    else $error("filter applied without support");

  chk_occ_reserved: assert property (
    !OCC_IRQ_SUPPORT |=> !OCC_IRQ_EN_EFF && OCC_LIMIT_EFF == '0)
    else $error("occupancy interrupt fields not reserved");

  chk_occ_live: assert property (
    OCC_SUPPORT |=> OCC_REPORT == $past(WQ_LIVE_FILL))
    else $error("occupancy not live");

  chk_prio_ignore: assert property (
    !PRIO_SUPPORT |=> PRIORITY_EFF == '0)
    else $error("priority used without support");

  chk_ats_follow: assert property (
    !ATS_SUPPORT ##1 1'b1 |-> ATS_USE == $past(ATS_ENABLE))
    else $error("translation use ignores enable");

  chk_mode_flag: assert property (
    WQ_CFG_VALID && WQ_MODE_DEDICATED && !DED_SUPPORT |=> MODE_ERROR)
    else $error("dedicated mode without support not flagged");

  chk_shared_flag: assert property (
    WQ_CFG_VALID && !WQ_MODE_DEDICATED && !SHR_SUPPORT |=> MODE_ERROR)
    else $error("shared mode without support not flagged");

  chk_fields_read: assert property (
    RD_REQ && cap_hit |=> RD_DATA[27:24] == CFG_SIZE_N &&
      RD_DATA[23:16] == NUM_QUEUES && RD_DATA[15:0] == TOTAL_STORAGE)
    else $error("size, count or storage field wrong");

  chk_unused_zero: assert property (
    RD_ACK |-> RD_DATA[63:56] == '0 && RD_DATA[47:28] == '0)
    else $error("unused bits not zero");

  chk_write_noeffect: assert property (
    WR_REQ && !RD_REQ |=> WR_ACK && $stable(RD_DATA))
    else $error("write disturbed the read data");

endmodule : work_queue_capability_register

/* File: sim/wq_host_model.sv */
// Host model issuing register reads and writes to the capability block
module wq_host_model (
  // Clock
  input wire logic CLK_SYS,
  // Register access towards the device
  output logic [11:0] ADDR,
  output logic RD_REQ,
  output logic WR_REQ,
  output logic [63:0] WR_DATA,
  input wire logic [63:0] RD_DATA,
  input wire logic RD_ACK,
  input wire logic WR_ACK
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial
  begin
    ADDR = 12'h000;
    RD_REQ = 1'b0;
    WR_REQ = 1'b0;
    WR_DATA = 64'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read: request over one taking edge, answer due one cycle later
  task automatic rd(input logic [11:0] a, output logic [63:0] d,
    output bit ok);
    @(negedge CLK_SYS);
    ADDR = a;
    RD_REQ = 1'b1;
    @(negedge CLK_SYS);
    ok = (RD_ACK === 1'b1);
    d = RD_DATA;
    RD_REQ = 1'b0;
    ADDR = ~a; // Released address shows no stale value
  endtask : rd

  // Write: data is dropped by the device, only the ack is expected
  task automatic wr(input logic [11:0] a, input logic [63:0] d,
    output bit ok);
    @(negedge CLK_SYS);
    ADDR = a;
    WR_DATA = d;
    WR_REQ = 1'b1;
    @(negedge CLK_SYS);
    ok = (WR_ACK === 1'b1);
    WR_REQ = 1'b0;
    WR_DATA = ~d;
  endtask : wr
endmodule : wq_host_model

/* File: sim/work_queue_capability_register_tb_top.sv */
// Testbench for the work-queue capability register block
module work_queue_capability_register_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] CAP_A = 64'h00aa000003100400;
  localparam logic [63:0] CAP_B = 64'h0055000003100400;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr;
  logic rd_req, wr_req, rd_ack_a, rd_ack_b, wr_ack_a, wr_ack_b;
  logic [63:0] wr_data, rd_data_a, rd_data_b;
  logic prs_dis, ats_dis, occ_irq_en;
  logic prs_en, ats_en, cfg_valid, mode_ded;
  logic [7:0] op_filter;
  logic [15:0] occ_limit, live_fill;
  logic [3:0] prio;
  logic [47:0] gate_a, gate_b;
  int num_errors = 0;
  int total_checks = 0;

  // Clock at 20 MHz
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two devices with opposite feature sets on one shared bus
  work_queue_capability_register #(.PRS_SUPPORT(1'b1), .OPFILT_SUPPORT(1'b0),
    .OCC_IRQ_SUPPORT(1'b1), .OCC_SUPPORT(1'b0), .PRIO_SUPPORT(1'b1),
    .ATS_SUPPORT(1'b0), .DED_SUPPORT(1'b1), .SHR_SUPPORT(1'b0),
    .CFG_SIZE_N(4'h3), .NUM_QUEUES(8'h10), .TOTAL_STORAGE(16'h0400)
  ) work_queue_capability_register_i (.CLK_SYS(clk_sys), .RST(rst),
    .ADDR(addr), .RD_REQ(rd_req), .WR_REQ(wr_req), .WR_DATA(wr_data),
    .RD_DATA(rd_data_a), .RD_ACK(rd_ack_a), .WR_ACK(wr_ack_a),
    .WQ_PRS_DISABLE(prs_dis), .PRS_ENABLE(prs_en), .WQ_ATS_DISABLE(ats_dis),
    .ATS_ENABLE(ats_en), .WQ_OP_FILTER(op_filter), .WQ_OCC_LIMIT(occ_limit),
    .WQ_OCC_IRQ_EN(occ_irq_en), .WQ_LIVE_FILL(live_fill),
    .WQ_PRIORITY(prio), .WQ_CFG_VALID(cfg_valid),
    .WQ_MODE_DEDICATED(mode_ded), .PRS_USE(gate_a[47]),
    .ATS_USE(gate_a[46]), .OP_ALLOWED(gate_a[45:38]),
    .OCC_LIMIT_EFF(gate_a[37:22]), .OCC_IRQ_EN_EFF(gate_a[21]),
    .OCC_REPORT(gate_a[20:5]), .PRIORITY_EFF(gate_a[4:1]),
    .MODE_ERROR(gate_a[0]));
  work_queue_capability_register #(.PRS_SUPPORT(1'b0), .OPFILT_SUPPORT(1'b1),
    .OCC_IRQ_SUPPORT(1'b0), .OCC_SUPPORT(1'b1), .PRIO_SUPPORT(1'b0),
    .ATS_SUPPORT(1'b1), .DED_SUPPORT(1'b0), .SHR_SUPPORT(1'b1),
    .CFG_SIZE_N(4'h3), .NUM_QUEUES(8'h10), .TOTAL_STORAGE(16'h0400)
  ) work_queue_capability_register_i2 (.CLK_SYS(clk_sys), .RST(rst),
    .ADDR(addr), .RD_REQ(rd_req), .WR_REQ(wr_req), .WR_DATA(wr_data),
    .RD_DATA(rd_data_b), .RD_ACK(rd_ack_b), .WR_ACK(wr_ack_b),
    .WQ_PRS_DISABLE(prs_dis), .PRS_ENABLE(prs_en), .WQ_ATS_DISABLE(ats_dis),
    .ATS_ENABLE(ats_en), .WQ_OP_FILTER(op_filter), .WQ_OCC_LIMIT(occ_limit),
    .WQ_OCC_IRQ_EN(occ_irq_en), .WQ_LIVE_FILL(live_fill),
    .WQ_PRIORITY(prio), .WQ_CFG_VALID(cfg_valid),
    .WQ_MODE_DEDICATED(mode_ded), .PRS_USE(gate_b[47]),
    .ATS_USE(gate_b[46]), .OP_ALLOWED(gate_b[45:38]),
    .OCC_LIMIT_EFF(gate_b[37:22]), .OCC_IRQ_EN_EFF(gate_b[21]),
    .OCC_REPORT(gate_b[20:5]), .PRIORITY_EFF(gate_b[4:1]),
    .MODE_ERROR(gate_b[0]));
  wq_host_model wq_host_model_i (.CLK_SYS(clk_sys), .ADDR(addr),
    .RD_REQ(rd_req), .WR_REQ(wr_req), .WR_DATA(wr_data),
    .RD_DATA(rd_data_a), .RD_ACK(rd_ack_a), .WR_ACK(wr_ack_a));

  //////////////////////////////////////////////////////////////////////////////
  // Value comparison with mismatch report
  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  // Final report and end of run
  task automatic conclude;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Read one address from both devices, missing ack counts as error
  task automatic rd_both(input logic [11:0] a, input logic [63:0] ea,
    input logic [63:0] eb);
    logic [63:0] d;
    bit ok;
    wq_host_model_i.rd(a, d, ok);
    compare({63'h0, ok}, 64'h1);
    compare({63'h0, rd_ack_b}, 64'h1);
    compare(d, ea);
    compare(rd_data_b, eb);
  endtask : rd_both

  // Set the configuration levels that the gating passes or blocks
  task automatic levels(input logic pe, input logic ae, input logic [7:0] f,
    input logic [15:0] l, input logic ie, input logic [15:0] lf);
    prs_en = pe;
    ats_en = ae;
    op_filter = f;
    occ_limit = l;
    occ_irq_en = ie;
    live_fill = lf;
  endtask : levels

  // Apply a queue configuration and check gated outputs one cycle later
  task automatic gate(input logic pd, input logic ad, input logic [3:0] p,
    input logic v, input logic md, input logic [47:0] ea,
    input logic [47:0] eb);
    @(negedge clk_sys);
    prs_dis = pd;
    ats_dis = ad;
    prio = p;
    cfg_valid = v;
    mode_ded = md;
    @(negedge clk_sys);
    compare({16'h0, gate_a}, {16'h0, ea});
    compare({16'h0, gate_b}, {16'h0, eb});
  endtask : gate

  // Bound on the whole run
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end

  // Main sequence
  initial
  begin
    bit ok;
    prs_dis = 1'b0;
    ats_dis = 1'b0;
    prio = 4'h0;
    cfg_valid = 1'b0;
    mode_ded = 1'b1;
    levels(1'b1, 1'b1, 8'h5a, 16'h1234, 1'b1, 16'h0077);
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    compare(rd_data_a, 64'h0);
    rd_both(12'h020, CAP_A, CAP_B);
    $display("test capability read done");
    wq_host_model_i.wr(12'h020, 64'hffffffffffffffff, ok);
    compare({63'h0, ok}, 64'h1);
    compare({63'h0, wr_ack_b}, 64'h1);
    compare(rd_data_a, CAP_A);
    compare(rd_data_b, CAP_B);
    rd_both(12'h020, CAP_A, CAP_B);
    rd_both(12'h028, 64'h0, 64'h0);
    $display("test write and unmapped done");
    gate(1'b1, 1'b1, 4'h5, 1'b1, 1'b1, {2'b01, 8'hff, 16'h1234, 1'b1,
      16'h0, 4'h5, 1'b0}, {2'b10, 8'h5a, 16'h0, 1'b0, 16'h0077, 4'h0,
      1'b1});
    gate(1'b0, 1'b0, 4'hf, 1'b1, 1'b0, {2'b11, 8'hff, 16'h1234, 1'b1,
      16'h0, 4'hf, 1'b1}, {2'b11, 8'h5a, 16'h0, 1'b0, 16'h0077, 4'h0,
      1'b0});
    gate(1'b0, 1'b0, 4'hf, 1'b0, 1'b0, {2'b11, 8'hff, 16'h1234, 1'b1,
      16'h0, 4'hf, 1'b0}, {2'b11, 8'h5a, 16'h0, 1'b0, 16'h0077, 4'h0,
      1'b0});
    levels(1'b0, 1'b0, 8'h3c, 16'h0abc, 1'b0, 16'h0123);
    gate(1'b1, 1'b0, 4'h9, 1'b1, 1'b1, {2'b00, 8'hff, 16'h0abc, 1'b0,
      16'h0, 4'h9, 1'b0}, {2'b00, 8'h3c, 16'h0, 1'b0, 16'h0123, 4'h0,
      1'b1});
    $display("test feature gating done");
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    compare({rd_data_a[15:0], gate_a}, 64'h0);
    rst = 1'b0;
    rd_both(12'h020, CAP_A, CAP_B);
    $display("test reset in mid-run done");
    conclude();
  end
endmodule : work_queue_capability_register_tb_top
